//--- jsd_pkg.sv
// shared constants and types for the scan packet decoder and its target end
package jsd_pkg;

   // opcode byte layout
   localparam logic [2:0] OP_TAG         = 3'h4;  // top three bits of a scan opcode
   localparam int         OP_TAG_LSB     = 5;     // position of the tag field
   localparam int         OP_FIX_EN_BIT  = 0;     // fixed_tdi_flag
   localparam int         OP_FIX_VAL_BIT = 1;     // fixed tdi level
   localparam int         OP_CAP_BIT     = 2;     // capture_tdo_flag
   localparam int         OP_TMS_BIT     = 3;     // tms level on the last cycle
   localparam int         OP_CTL_W       = 4;     // control bits kept from the opcode

   // length byte layout
   localparam int         LEN_PACKED_BIT = 7;     // set selects packed format
   localparam logic [7:0] LEN_ONE        = 8'h01; // normal length is field plus one
   localparam logic [7:0] BYTE_ZERO      = 8'h00; // cleared byte value

   // timing: tck half period as a time and as clock cycles
   localparam int         CLK_PERIOD_NS  = 10;    // engine clock period
   localparam int         TCK_HALF_NS    = 40;    // tck half period
   localparam int         TCK_HALF_CYC   = (TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // target chain defaults
   localparam int          TGT_CHAIN_W   = 32;            // chain length in bits
   localparam logic [31:0] TGT_CHAIN_RST = 32'hc3a5_5a3c; // chain contents after reset

   // decoder states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,  // waiting for an opcode
      ST_LEN   = 5'h02,  // waiting for the length byte
      ST_DATA  = 5'h04,  // waiting for a tdi data byte
      ST_SHIFT = 5'h08,  // running tck cycles
      ST_RESP  = 5'h10   // offering a captured tdo byte
   } jsd_state_e;

endpackage

//--- jsd_link_if.sv
// test access port link between the scan decoder and the target chain
interface jsd_link_if;
   logic tck;        // test clock, made by the decoder
   logic tms;        // mode select
   logic tdi;        // data into the chain
   logic tdo;        // data out of the chain
   logic tap_rst_n;  // test reset, active low

   // decoder end
   modport device (
      output tck,
      output tms,
      output tdi,
      output tap_rst_n,
      input  tdo
   );

   // chain end
   modport target (
      input  tck,
      input  tms,
      input  tdi,
      input  tap_rst_n,
      output tdo
   );
endinterface

//--- jsd_tap_target.sv
// target chain end: a shift chain clocked by tck with a snapshot for the user
module jsd_tap_target #(
   parameter int                             CHAIN_W   = jsd_pkg::TGT_CHAIN_W,
   parameter logic [jsd_pkg::TGT_CHAIN_W-1:0] CHAIN_RST = jsd_pkg::TGT_CHAIN_RST
) (
   // user clock and reset
   input  wire logic               clk_i,
   input  wire logic               srst_i,
   // link
   jsd_link_if.target              link,
   // user side
   output logic [CHAIN_W-1:0]      chain_o,
   output logic                    scan_done_o
);
   import jsd_pkg::*;

   logic [CHAIN_W-1:0] chain_q;   // live shift chain, tck domain
   logic [CHAIN_W-1:0] snap_q;    // chain copy at a tms-high cycle
   logic               tgl_q;     // flips on each snapshot
   logic               tdo_q;     // tdo, changes on falling tck
   logic               tgl_s1_q;  // synchroniser first stage
   logic               tgl_s2_q;  // synchroniser second stage
   logic               tgl_s3_q;  // previous synchronised value
   wire  [CHAIN_W-1:0] chain_nx = {link.tdi, chain_q[CHAIN_W-1:1]};  // after one shift

   // rising tck: shift, and snapshot when tms marks the last cycle
   // reset comes from the link pin because tck does not run outside scans
   always_ff @(posedge link.tck or negedge link.tap_rst_n) begin
      if (!link.tap_rst_n) begin
         chain_q <= CHAIN_RST;
         snap_q  <= CHAIN_RST;
         tgl_q   <= 1'b0;
      end else begin
         chain_q <= chain_nx;
         if (link.tms) begin
            snap_q <= chain_nx;
            tgl_q  <= ~tgl_q;
         end
      end
   end

   // falling tck: present the next chain bit, as a tap does
   always_ff @(negedge link.tck or negedge link.tap_rst_n) begin
      if (!link.tap_rst_n) begin
         // first scan after reset must see chain bit 0 before any falling tck
         tdo_q <= CHAIN_RST[0];
      end else begin
         tdo_q <= chain_q[0];
      end
   end

   assign link.tdo = tdo_q;

   // toggle crossing into the user clock
   // snap_q is read only after the toggle settles; it cannot move again
   // for at least one tck period, far longer than the three-flop latency
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tgl_s1_q    <= 1'b0;
         tgl_s2_q    <= 1'b0;
         tgl_s3_q    <= 1'b0;
         chain_o     <= CHAIN_RST;
         scan_done_o <= 1'b0;
      end else begin
         tgl_s1_q    <= tgl_q;
         tgl_s2_q    <= tgl_s1_q;
         tgl_s3_q    <= tgl_s2_q;
         scan_done_o <= tgl_s2_q ^ tgl_s3_q;
         if (tgl_s2_q ^ tgl_s3_q) begin
            chain_o <= snap_q;
         end
      end
   end
endmodule

//--- jsd_scan_engine.sv
// scan packet decoder: takes opcode, length and data bytes and drives the tap
// Behaviour
// R1 - length bit 7 low: scan of field plus one
// R2 - normal, not fixed: tdi from following data bytes
// R3 - normal and fixed: packet ends after length byte
// R4 - length bit 7 high: highest flag gives length
// R5 - packed, not fixed: tdi from bits below flag
// R6 - packed and fixed: tdi held at opcode level
// R7 - packed packet ends after the length byte
// R8 - source uses packed format only up to six
// R9 - consume length/8 rounded up bytes, lsb first
// R10 - source zero-fills unused bits of final byte
// R11 - opcode bit 3 sets tms on last cycle
// R12 - opcode bit 2 captures tdo every cycle
// R13 - top bits 100 mark a scan opcode
// R14 - opcode bit 0 fixes tdi at bit 1
// R15 - tms low on all cycles before last
// R16 - stall while captured byte waits for space
// R17 - one bit per tck, data byte first
// R18 - packed byte without flag runs no scan
module jsd_scan_engine #(
   parameter int TCK_HALF = jsd_pkg::TCK_HALF_CYC  // clk cycles per tck half period
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // command byte stream
   input  wire logic [7:0]  cmd_data_i,
   input  wire logic        cmd_valid_i,
   output logic             cmd_ready_o,
   // captured tdo bytes
   output logic [7:0]       rsp_data_o,
   output logic             rsp_valid_o,
   input  wire logic        rsp_ready_i,
   // status
   output logic             busy_o,
   output logic             bad_len_o,
   // link
   jsd_link_if.device       link
);
   import jsd_pkg::*;

   localparam logic [7:0] PH_HIGH = 8'(TCK_HALF - 1);      // step before tck rises
   localparam logic [7:0] PH_LAST = 8'(2 * TCK_HALF - 1);  // last step of a tck period

   // state and working registers
   jsd_state_e         st_q;        // decoder state
   jsd_state_e         st_d;        // next decoder state
   logic [OP_CTL_W-1:0] op_q;       // control bits of the opcode
   logic [7:0]         len_q;       // scan length in cycles
   logic [7:0]         cyc_q;       // cycles completed
   logic [7:0]         tdi_buf_q;   // current tdi source byte
   logic               need_q;      // tdi comes from data bytes
   logic [7:0]         ph_q;        // step within a tck period
   logic [7:0]         acc_q;       // tdo bits of the current byte
   logic               tdo_s1_q;    // tdo synchroniser first stage
   logic               tdo_s2_q;    // tdo synchroniser second stage
   logic               tck_q;       // tck pin
   logic               tms_q;       // tms pin
   logic               tdi_q;       // tdi pin
   logic               trst_n_q;    // test reset pin

   // byte handshake and opcode decode
   wire take = cmd_valid_i & cmd_ready_o;  // a command byte moves this cycle
   // R13 tag check only; the reserved bit is not checked
   wire op_hit = (cmd_data_i[7:OP_TAG_LSB] == OP_TAG);

   // opcode control bits
   wire fix_en  = op_q[OP_FIX_EN_BIT];
   wire fix_val = op_q[OP_FIX_VAL_BIT];
   wire cap_en  = op_q[OP_CAP_BIT];
   wire tms_end = op_q[OP_TMS_BIT];

   // length byte decode
   wire       packed_fmt = cmd_data_i[LEN_PACKED_BIT];
   // R1 normal length
   wire [7:0] norm_len = 8'({1'b0, cmd_data_i[6:0]} + LEN_ONE);
   // R4 highest flag wins
   wire [2:0] pack_len = cmd_data_i[6] ? 3'h6 :
                         cmd_data_i[5] ? 3'h5 :
                         cmd_data_i[4] ? 3'h4 :
                         cmd_data_i[3] ? 3'h3 :
                         cmd_data_i[2] ? 3'h2 :
                         cmd_data_i[1] ? 3'h1 : 3'h0;
   // R18 no flag found
   wire       pack_bad = packed_fmt & (pack_len == 3'h0);

   // scan progress decode
   wire last_bit = (8'(cyc_q + LEN_ONE) == len_q);  // cycle in flight is the last
   wire all_done = (cyc_q == len_q);                // every cycle has run
   wire byte_end = (cyc_q[2:0] == 3'h7);            // cycle in flight ends a byte
   wire ph_last  = (ph_q == PH_LAST);               // tck period ends this cycle
   // R14 fixed level or packet bit
   wire cur_tdi  = fix_en ? fix_val : tdi_buf_q[cyc_q[2:0]];
   // R12 tdo bit joined into the byte
   wire [7:0] acc_nx = acc_q | 8'({7'h00, tdo_s2_q} << cyc_q[2:0]);

   // where to go once a byte boundary has been handled
   function automatic jsd_state_e after_byte(input logic fin, input logic fetch);
      if (fin) begin
         after_byte = ST_IDLE;    // packet over, next byte is an opcode
      end else if (fetch) begin
         after_byte = ST_DATA;    // next cycles, up to eight, need a new data byte
      end else begin
         after_byte = ST_SHIFT;   // same source byte keeps going
      end
   endfunction

   // next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            // other packet kinds are not ours and are swallowed
            if (take && op_hit) begin
               st_d = ST_LEN;
            end
         end
         ST_LEN: begin
            if (take) begin
               if (!packed_fmt) begin
                  // R2 fetch data first
                  // R3 fixed tdi: two-byte packet
                  st_d = fix_en ? ST_SHIFT : ST_DATA;
               end else begin
                  // R7 packed packet ends here
                  // R18 invalid length: back to opcode
                  st_d = pack_bad ? ST_IDLE : ST_SHIFT;
               end
            end
         end
         ST_DATA: begin
            // R17 byte in hand before its cycles
            if (take) begin
               st_d = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (ph_last) begin
               if (cap_en && (byte_end || last_bit)) begin
                  st_d = ST_RESP;
               end else begin
                  // R9 one byte per eight cycles
                  st_d = after_byte(last_bit, need_q && byte_end);
               end
            end
         end
         ST_RESP: begin
            // R16 hold the scan until the byte is taken
            if (rsp_ready_i) begin
               st_d = after_byte(all_done, need_q);
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // state and stream handshake flops
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q        <= ST_IDLE;
         cmd_ready_o <= 1'b0;
         busy_o      <= 1'b0;
         bad_len_o   <= 1'b0;
      end else begin
         st_q        <= st_d;
         cmd_ready_o <= (st_d == ST_IDLE) || (st_d == ST_LEN) || (st_d == ST_DATA);
         busy_o      <= (st_d != ST_IDLE);
         bad_len_o   <= (st_q == ST_LEN) && take && pack_bad;
      end
   end

   // packet fields captured from the stream
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         op_q      <= '0;
         len_q     <= BYTE_ZERO;
         tdi_buf_q <= BYTE_ZERO;
         need_q    <= 1'b0;
      end else if (take) begin
         if (st_q == ST_IDLE && op_hit) begin
            op_q <= cmd_data_i[OP_CTL_W-1:0];
         end
         if (st_q == ST_LEN) begin
            // R5 packed bits drive tdi from bit 0; R6 ignored when fixed
            len_q     <= packed_fmt ? {5'h00, pack_len} : norm_len;
            tdi_buf_q <= cmd_data_i;
            need_q    <= !packed_fmt && !fix_en;
         end
         // R10 unused high bits are never shifted out
         if (st_q == ST_DATA) begin
            tdi_buf_q <= cmd_data_i;
         end
      end
   end

   // cycle counter and tck period steps
   always_ff @(posedge clk_i) begin
      if (srst_i || (st_q == ST_LEN)) begin
         cyc_q <= BYTE_ZERO;
         ph_q  <= BYTE_ZERO;
      end else if (st_q == ST_SHIFT) begin
         // R17 one bit per tck period
         ph_q <= ph_last ? BYTE_ZERO : 8'(ph_q + LEN_ONE);
         if (ph_last) begin
            cyc_q <= 8'(cyc_q + LEN_ONE);
         end
      end
   end

   // tdo synchroniser, the pin is in the tck domain
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tdo_s1_q <= 1'b0;
         tdo_s2_q <= 1'b0;
      end else begin
         tdo_s1_q <= link.tdo;
         tdo_s2_q <= tdo_s1_q;
      end
   end

   // tdo byte assembly; bits not reached stay zero as padding
   always_ff @(posedge clk_i) begin
      if (srst_i || (st_q == ST_LEN) || (st_q == ST_RESP && rsp_ready_i)) begin
         acc_q <= BYTE_ZERO;
      end else if (st_q == ST_SHIFT && ph_last && cap_en) begin
         // R12 sampled at the end of the high phase
         acc_q <= acc_nx;
      end
   end

   // response byte offer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rsp_valid_o <= 1'b0;
         rsp_data_o  <= BYTE_ZERO;
      end else if (st_q == ST_SHIFT && st_d == ST_RESP) begin
         rsp_valid_o <= 1'b1;
         rsp_data_o  <= acc_nx;
      end else if (rsp_ready_i) begin
         rsp_valid_o <= 1'b0;
      end
   end

   // link pins; tdi and tms move only while tck is low
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tck_q    <= 1'b0;
         tms_q    <= 1'b0;
         tdi_q    <= 1'b0;
         trst_n_q <= 1'b0;
      end else begin
         trst_n_q <= 1'b1;
         // tck is gated: it runs only while a scan is shifting
         tck_q    <= (st_q == ST_SHIFT) && !ph_last && (ph_q >= PH_HIGH);
         if (st_q == ST_SHIFT && ph_q == BYTE_ZERO) begin
            tdi_q <= cur_tdi;
            // R11 last cycle level from opcode
            // R15 earlier cycles low
            tms_q <= last_bit & tms_end;
         end
      end
   end

   assign link.tck       = tck_q;
   assign link.tms       = tms_q;
   assign link.tdi       = tdi_q;
   assign link.tap_rst_n = trst_n_q;
endmodule

//--- jsd_link_props.sv
// assertions on the tap link and the engine byte streams
module jsd_link_props #(
   parameter int TCK_HALF = 4  // clk cycles per tck half period
) (
   // clock and reset
   input wire logic       clk_i,
   input wire logic       srst_i,
   // link
   input wire logic       tck,
   input wire logic       tms,
   input wire logic       tdi,
   // engine streams
   input wire logic [7:0] cmd_data_i,
   input wire logic       cmd_valid_i,
   input wire logic       cmd_ready_o,
   input wire logic [7:0] rsp_data_o,
   input wire logic       rsp_valid_o,
   input wire logic       rsp_ready_i,
   input wire logic       busy_o,
   input wire logic       bad_len_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   int  hi_q;                                          // cycles tck has stood high
   wire take_w = cmd_valid_i && cmd_ready_o && !busy_o; // byte taken while idle
   wire op_w   = take_w && (cmd_data_i[7:5] == 3'h4);   // that byte is a scan opcode
   // high phase counter, cleared while tck is low
   always_ff @(posedge clk_i) begin
      if (srst_i || !tck) hi_q <= 0;
      else hi_q <= hi_q + 1;
   end
   a_tck_high_len: assert property ($fell(tck) |-> hi_q == TCK_HALF)
      else $error("tck high phase has wrong length");
   a_link_steady: assert property (tck && $past(tck) |-> $stable(tdi) && $stable(tms))
      else $error("tdi or tms moved while tck high");
   // no tck while a byte waits
   a_stall_no_tck: assert property (rsp_valid_o |-> !tck)
      else $error("tck ran while a response byte waited");
   a_rsp_hold: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_data_o))
      else $error("response byte dropped or changed before taken");
   a_ready_no_tck: assert property (cmd_ready_o |-> !tck)
      else $error("tck ran while bytes were accepted");
   a_opcode_busy: assert property (op_w |-> ##[1:2] busy_o)
      else $error("scan opcode did not start a packet");
   a_junk_dropped: assert property (take_w && !op_w |=> !busy_o)
      else $error("non opcode byte started a packet");
   a_bad_len_pulse: assert property (bad_len_o |-> !tck ##1 !bad_len_o)
      else $error("bad length pulse too long or with tck");
   c_bad: cover property (bad_len_o);
   c_stall: cover property (rsp_valid_o && !rsp_ready_i);
   c_tms: cover property ($rose(tms));
endmodule

//--- jtag_scan_packet_decoder_bench.sv
// testbench: scan engine against the target chain over the tap link
module jtag_scan_packet_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import jsd_pkg::*;
   localparam int TH = 4;         // tck half period in clk cycles
   logic        clk_i = 1'b0;     // engine clock
   logic        clk2 = 1'b0;      // target user clock, 12 ns
   logic        srst_i = 1'b1;    // shared sync reset
   logic [7:0]  cmd_data_i = 8'h00;
   logic        cmd_valid_i = 1'b0;
   logic        cmd_ready_o;
   logic [7:0]  rsp_data_o;
   logic        rsp_valid_o;
   logic        rsp_ready_i = 1'b1;
   logic        busy_o;
   logic        bad_len_o;
   logic        scan_done_o;
   logic [31:0] chain_o;
   int          num_errors = 0;
   int          n_checks = 0;
   int          stall = 0;        // response stall cycles left
   int          bad_n = 0;        // bad length pulses seen
   int          done_n = 0;       // target snapshot pulses seen
   logic        tdi_q[$];         // tdi per tck cycle
   logic        tms_q[$];         // tms per tck cycle
   logic [7:0]  rsp_q[$];         // response bytes taken
   logic [7:0]  none[$];          // no data bytes
   jsd_link_if lk ();
   always #5 clk_i = ~clk_i;
   always #6 clk2 = ~clk2;
   jsd_scan_engine #(.TCK_HALF(TH)) u_jsd_scan_engine (.clk_i(clk_i), .srst_i(srst_i),
      .cmd_data_i(cmd_data_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
      .rsp_data_o(rsp_data_o), .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i),
      .busy_o(busy_o), .bad_len_o(bad_len_o), .link(lk));
   jsd_tap_target u_jsd_tap_target (.clk_i(clk2), .srst_i(srst_i), .link(lk),
      .chain_o(chain_o), .scan_done_o(scan_done_o));
   jsd_link_props #(.TCK_HALF(TH)) u_jsd_link_props (.clk_i(clk_i), .srst_i(srst_i),
      .tck(lk.tck), .tms(lk.tms), .tdi(lk.tdi), .cmd_data_i(cmd_data_i),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .rsp_data_o(rsp_data_o),
      .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .busy_o(busy_o),
      .bad_len_o(bad_len_o));
   // link levels as the target samples them
   always @(posedge lk.tck) begin
      tdi_q.push_back(lk.tdi);
      tms_q.push_back(lk.tms);
   end
   // response taker and pulse counter
   always @(posedge clk_i) begin
      if (rsp_valid_o && rsp_ready_i) rsp_q.push_back(rsp_data_o);
      if (bad_len_o) bad_n++;
   end
   // snapshot pulses from the target user side
   always @(posedge clk2) begin
      if (scan_done_o) done_n++;
   end
   // stall makes the far queue look full for a while
   always @(negedge clk_i) begin
      rsp_ready_i <= (stall == 0);
      if (stall > 0) stall--;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // hold the byte until a ready edge has taken it
   task automatic send(input logic [7:0] b);
      @(negedge clk_i);
      cmd_data_i = b;
      cmd_valid_i = 1'b1;
      while (cmd_ready_o !== 1'b1) @(negedge clk_i);
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
   endtask
   // one packet, then judge the tck cycles and response count
   task automatic run(input logic [7:0] op, input logic [7:0] lb, input logic [7:0] d[$],
                      input int n, input logic [127:0] e);
      tdi_q.delete();
      tms_q.delete();
      rsp_q.delete();
      send(op);
      send(lb);
      foreach (d[i]) send(d[i]);
      repeat (3) @(negedge clk_i);
      while (busy_o !== 1'b0) @(negedge clk_i);
      chk(32'(tdi_q.size()), 32'(n));
      for (int i = 0; i < n; i++) begin
         chk(32'(tdi_q[i]), 32'(e[i]));
         chk(32'(tms_q[i]), (i == n - 1) ? 32'(op[3]) : 32'h0);
      end
      chk(32'(rsp_q.size()), op[2] ? 32'((n + 7) / 8) : 32'h0);
   endtask
   // junk byte, then a 32 cycle scan that refills the chain
   task automatic t_load;
      send(8'h5a);
      run(8'h88, 8'h1f, '{8'ha5, 8'h3c, 8'h0f, 8'h96}, 32, 128'h960f3ca5);
      repeat (10) @(posedge clk2);
      chk(chain_o, 32'h960f3ca5);
      chk(32'(done_n), 32'h1);
      $display("test load done");
   endtask
   // 21 cycle capture with the response side stalled
   task automatic t_capture;
      stall = 300;
      run(8'h8c, 8'h14, '{8'h12, 8'h34, 8'h05}, 21, 128'h053412);
      chk(32'(rsp_q[0]), 32'ha5);
      chk(32'(rsp_q[1]), 32'h3c);
      chk(32'(rsp_q[2]), 32'h0f);
      repeat (10) @(posedge clk2);
      chk(chain_o, 32'h29a0_94b0);
      $display("test capture done");
   endtask
   // packed lengths 1..6 back to back, then packed with fixed tdi
   task automatic t_packed;
      logic [7:0] m;
      for (int k = 1; k <= 6; k++) begin
         m = (8'h01 << k) - 8'h01;
         run(8'h82, 8'h80 | (8'h01 << k) | (8'h2b & m), none, k, 128'(8'h2b & m));
      end
      run(8'h83, 8'h8a, none, 3, 128'h7);
      $display("test packed done");
   endtask
   // longest fixed scan, then shortest, back to back
   task automatic t_fixed;
      run(8'h81, 8'h7f, none, 128, 128'h0);
      run(8'h8b, 8'h00, none, 1, 128'h1);
      $display("test fixed done");
   endtask
   // packed bytes with no start flag
   task automatic t_bad_len;
      bad_n = 0;
      run(8'h80, 8'h80, none, 0, 128'h0);
      run(8'h80, 8'h81, none, 0, 128'h0);
      chk(32'(bad_n), 32'h2);
      $display("test bad_len done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
      srst_i = 1'b0;
      t_load();
      t_capture();
      t_packed();
      t_fixed();
      t_bad_len();
      report_and_stop();
   end
   // watchdog, far past the expected run
   initial begin
      #200us;
      num_errors++;
      report_and_stop();
   end
endmodule
